// ==== hdl/i2ac_pkg.sv ====
// register map, field positions, reset values and state codes of the two-wire controller
package i2ac_pkg;
	// ---------------------------------------------------------------
	// register byte addresses
	// ---------------------------------------------------------------
	localparam logic [31:0] ADDR_MRX = 32'hFFFF0908;
	localparam logic [31:0] ADDR_MTX = 32'hFFFF090C;
	localparam logic [31:0] ADDR_MCNT = 32'hFFFF0910;
	localparam logic [31:0] ADDR_PROG = 32'hFFFF0914;
	localparam logic [31:0] ADDR_ADR0 = 32'hFFFF0918;
	localparam logic [31:0] ADDR_ADR1 = 32'hFFFF091C;
	localparam logic [31:0] ADDR_DIV = 32'hFFFF0924;
	localparam logic [31:0] ADDR_SCON = 32'hFFFF0928;
	localparam logic [31:0] ADDR_MCTL = 32'hFFFF0930;
	localparam logic [31:0] ADDR_IST = 32'hFFFF0934;
	localparam logic [31:0] ADDR_IMSK = 32'hFFFF0938;
	localparam logic [31:0] ADDR_SOWN = 32'hFFFF093C;
	localparam logic [31:0] ADDR_STX = 32'hFFFF0940;
	// one-hot select positions
	localparam int R_MRX = 0;
	localparam int R_MTX = 1;
	localparam int R_MCNT = 2;
	localparam int R_PROG = 3;
	localparam int R_ADR0 = 4;
	localparam int R_ADR1 = 5;
	localparam int R_DIV = 6;
	localparam int R_SCON = 7;
	localparam int R_MCTL = 8;
	localparam int R_IST = 9;
	localparam int R_IMSK = 10;
	localparam int R_SOWN = 11;
	localparam int R_STX = 12;
	localparam int NREG = 13;
	// ---------------------------------------------------------------
	// fields and reset values
	// ---------------------------------------------------------------
	localparam int SCON_STXENI = 10;
	localparam int SCON_SEN = 0;
	localparam int CTL_GO = 0;
	localparam int CTL_TEN = 1;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_MRX = 1;
	localparam int IRQ_NACK = 2;
	localparam int IRQ_STX = 3;
	localparam logic [15:0] DIV_RST = 16'h1F1F;
	localparam logic [8:0] MCNT_RST = 9'h000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam logic [4:0] TEN_PREFIX = 5'h1E;
	// ---------------------------------------------------------------
	// state codes
	// ---------------------------------------------------------------
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01, ST_START = 8'h02, ST_LOW = 8'h04, ST_HIGH = 8'h08,
		ST_STOP_LOW = 8'h10, ST_STOP_HIGH = 8'h20, ST_RS_LOW = 8'h40, ST_RS_HIGH = 8'h80
	} i2ac_state_e;
	typedef enum logic [3:0] {BY_ADDR = 4'h1, BY_ADDR2 = 4'h2, BY_TX = 4'h4, BY_RX = 4'h8} i2ac_byte_e;
	typedef enum logic [3:0] {SL_IDLE = 4'h1, SL_ADDR = 4'h2, SL_TX = 4'h4, SL_SKIP = 4'h8} i2ac_slave_e;
endpackage : i2ac_pkg

// ==== hdl/i2ac_sync.sv ====
// two-stage synchroniser for the clock and data pins
`timescale 1ns/1ps
module i2ac_sync (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [1:0] din,
	output logic [1:0] dout
);
	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] sync;
	} i2ac_sync_s;
	i2ac_sync_s s, n;
	// first stage feeds only the second
	always_comb begin
		n = s;
		n.meta = din;
		n.sync = s.meta;
	end
	// idle bus is high, so both stages reset high
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '1;
		end else begin
			s <= n;
		end
	end
	assign dout = s.sync;
endmodule : i2ac_sync

// ==== hdl/i2ac_timer.sv ====
// phase timer: done comes len+1 cycles after a load
`timescale 1ns/1ps
module i2ac_timer (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic load,
	input wire logic [7:0] len,
	output logic done
);
	typedef struct packed {
		logic busy;
		logic [7:0] cnt;
	} i2ac_tmr_s;
	i2ac_tmr_s s, n;
	// count down to zero, then go quiet until the next load
	always_comb begin
		n = s;
		if (load) begin
			n.busy = 1'b1;
			n.cnt = len;
		end else if (s.busy) begin
			if (s.cnt == 8'h00) begin
				n.busy = 1'b0;
			end else begin
				n.cnt = s.cnt - 8'h01;
			end
		end
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
	assign done = s.busy && (s.cnt == 8'h00);
endmodule : i2ac_timer

// ==== hdl/i2ac_top.sv ====
// two-wire controller: apb registers, master engine and slave byte transmitter
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module i2ac_top
	import i2ac_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic sclIn,
	output logic sclOut,
	output logic sclOe,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe
);
	typedef struct packed {
		i2ac_state_e st;
		i2ac_byte_e by;
		i2ac_slave_e sl;
		logic [8:0] rdCnt;
		logic [7:0] adr0;
		logic [7:0] adr1;
		logic [15:0] div;
		logic [10:0] scon;
		logic tenBit;
		logic [7:0] txHold;
		logic txValid;
		logic [7:0] shift;
		logic [3:0] bitIdx;
		logic [8:0] rxLeft;
		logic [7:0] prog;
		logic [7:0] rxData;
		logic isRead;
		logic restarted;
		logic sclLow;
		logic sdaLow;
		logic tmrGo;
		logic [3:0] irqSt;
		logic [3:0] irqMsk;
		logic [6:0] sOwn;
		logic [7:0] sTx;
		logic [7:0] sShift;
		logic [3:0] sCnt;
		logic sSdaLow;
		logic sclPrev;
		logic sdaPrev;
		logic [31:0] rdata;
	} i2ac_regs_s;
	i2ac_regs_s s, n;
	logic [1:0] pinS;
	logic sclS, sdaS, tmrRaw, tmrDone;
	logic [7:0] tmrLen;
	logic [NREG-1:0] sel;
	logic wrAcc, rdAcc, goReq, rxEvt, nackEvt, doneEvt, stxEvt;
	logic contin, stopNow, nextTx, sRise, sFall, sStart, sStop;
	logic [31:0] rdMux;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// apb address to one-hot register select
	function automatic logic [NREG-1:0] decodeReg(logic [31:0] a);
		logic [NREG-1:0] h;
		h = '0;
		if (a == ADDR_MRX) h[R_MRX] = 1'b1;
		else if (a == ADDR_MTX) h[R_MTX] = 1'b1;
		else if (a == ADDR_MCNT) h[R_MCNT] = 1'b1;
		else if (a == ADDR_PROG) h[R_PROG] = 1'b1;
		else if (a == ADDR_ADR0) h[R_ADR0] = 1'b1;
		else if (a == ADDR_ADR1) h[R_ADR1] = 1'b1;
		else if (a == ADDR_DIV) h[R_DIV] = 1'b1;
		else if (a == ADDR_SCON) h[R_SCON] = 1'b1;
		else if (a == ADDR_MCTL) h[R_MCTL] = 1'b1;
		else if (a == ADDR_IST) h[R_IST] = 1'b1;
		else if (a == ADDR_IMSK) h[R_IMSK] = 1'b1;
		else if (a == ADDR_SOWN) h[R_SOWN] = 1'b1;
		else if (a == ADDR_STX) h[R_STX] = 1'b1;
		return h;
	endfunction : decodeReg

	// sda level for the coming low phase: data bit, ack, or release
	function automatic logic lowDrive(i2ac_byte_e by, logic [3:0] idx, logic [7:0] sh, logic [8:0] left);
		logic d;
		d = 1'b0;
		if (idx == ACK_BIT) d = (by == BY_RX) && (left != 9'h000);
		else if (by != BY_RX) d = !sh[7];
		return d;
	endfunction : lowDrive

	// ---------------------------------------------------------------
	// submodules
	// ---------------------------------------------------------------
	i2ac_sync uSync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.din({sclIn, sdaIn}),
		.dout(pinS)
	);
	i2ac_timer uTimer (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.load(s.tmrGo),
		.len(tmrLen),
		.done(tmrRaw)
	);
	assign sclS = pinS[1];
	assign sdaS = pinS[0];
	// high phases use the upper divider byte, all others the lower
	assign tmrLen = (s.st inside {ST_START, ST_HIGH, ST_STOP_HIGH, ST_RS_HIGH}) ? s.div[15:8] : s.div[7:0];
	// a done seen in the load cycle belongs to the previous phase
	assign tmrDone = tmrRaw && !s.tmrGo;

	// ---------------------------------------------------------------
	// apb decode and read mux
	// ---------------------------------------------------------------
	assign sel = decodeReg(paddr);
	assign wrAcc = psel && penable && pwrite;
	assign rdAcc = psel && penable && !pwrite;
	assign goReq = wrAcc && sel[R_MCTL] && pwdata[CTL_GO];
	assign pready = 1'b1;
	assign pslverr = psel && penable && (sel == '0);
	assign prdata = s.rdata;
	// write-only transmit register reads as zero
	always_comb begin
		rdMux = '0;
		if (sel[R_MRX]) rdMux[7:0] = s.rxData;
		else if (sel[R_MCNT]) rdMux[8:0] = s.rdCnt;
		else if (sel[R_PROG]) rdMux[7:0] = s.prog;
		else if (sel[R_ADR0]) rdMux[7:0] = s.adr0;
		else if (sel[R_ADR1]) rdMux[7:0] = s.adr1;
		else if (sel[R_DIV]) rdMux[15:0] = s.div;
		else if (sel[R_SCON]) rdMux[10:0] = s.scon;
		else if (sel[R_MCTL]) rdMux[1:0] = {s.tenBit, s.st != ST_IDLE};
		else if (sel[R_IST]) rdMux[3:0] = s.irqSt;
		else if (sel[R_IMSK]) rdMux[3:0] = s.irqMsk;
		else if (sel[R_SOWN]) rdMux[6:0] = s.sOwn;
		else if (sel[R_STX]) rdMux[7:0] = s.sTx;
	end

	// ---------------------------------------------------------------
	// next state: master engine, slave, registers, interrupts
	// ---------------------------------------------------------------
	always_comb begin
		n = s;
		n.tmrGo = 1'b0;
		contin = 1'b0;
		stopNow = 1'b0;
		nextTx = 1'b0;
		rxEvt = 1'b0;
		nackEvt = 1'b0;
		doneEvt = 1'b0;
		stxEvt = 1'b0;
		// master sequencer, one clock phase per state
		case (s.st)
			ST_IDLE: if (goReq) begin
				n.st = ST_START;
				n.tmrGo = 1'b1;
				n.sdaLow = 1'b1;
				n.by = BY_ADDR;
				n.bitIdx = 4'h0;
				n.restarted = 1'b0;
				n.rxLeft = s.rdCnt;
				n.prog = BYTE_RST;
				n.isRead = s.adr0[0];
				// 10-bit header always goes out as a write first; the mode bit rides on this same write
				n.shift = pwdata[CTL_TEN] ? {s.adr0[7:1], 1'b0} : s.adr0;
			end
			ST_START: if (tmrDone) begin
				contin = 1'b1;
			end
			ST_LOW: if (tmrDone) begin
				n.st = ST_HIGH;
				n.sclLow = 1'b0;
				n.tmrGo = 1'b1;
			end
			ST_HIGH: if (tmrDone) begin
				if (s.bitIdx != ACK_BIT) begin
					n.shift = {s.shift[6:0], sdaS};
					n.bitIdx = s.bitIdx + 4'h1;
					contin = 1'b1;
				end else begin
					n.bitIdx = 4'h0;
					case (s.by)
						BY_ADDR: if (sdaS) begin
							nackEvt = 1'b1;
							stopNow = 1'b1;
						end else if (s.tenBit && !s.restarted) begin
							n.by = BY_ADDR2;
							n.shift = s.adr1;
							contin = 1'b1;
						end else if (s.isRead) begin
							n.by = BY_RX;
							contin = 1'b1;
						end else begin
							nextTx = 1'b1;
						end
						BY_ADDR2: if (sdaS) begin
							nackEvt = 1'b1;
							stopNow = 1'b1;
						end else if (s.isRead) begin
							// repeated start, then header with read bit
							n.st = ST_RS_LOW;
							n.sclLow = 1'b1;
							n.sdaLow = 1'b0;
							n.tmrGo = 1'b1;
							n.restarted = 1'b1;
						end else begin
							nextTx = 1'b1;
						end
						BY_TX: if (sdaS) begin
							nackEvt = 1'b1;
							stopNow = 1'b1;
						end else begin
							nextTx = 1'b1;
						end
						default: begin
							rxEvt = 1'b1;
							n.rxData = s.shift;
							n.prog = s.prog + 8'h01;
							if (s.rxLeft == 9'h000) begin
								stopNow = 1'b1;
							end else begin
								n.rxLeft = s.rxLeft - 9'h001;
								contin = 1'b1;
							end
						end
					endcase
				end
			end
			ST_STOP_LOW: if (tmrDone) begin
				n.st = ST_STOP_HIGH;
				n.sclLow = 1'b0;
				n.tmrGo = 1'b1;
			end
			ST_STOP_HIGH: if (tmrDone) begin
				n.st = ST_IDLE;
				n.sdaLow = 1'b0;
				doneEvt = 1'b1;
			end
			ST_RS_LOW: if (tmrDone) begin
				n.st = ST_RS_HIGH;
				n.sclLow = 1'b0;
				n.tmrGo = 1'b1;
			end
			default: if (tmrDone) begin
				n.st = ST_START;
				n.sdaLow = 1'b1;
				n.tmrGo = 1'b1;
				n.by = BY_ADDR;
				n.shift = {s.adr0[7:1], 1'b1};
			end
		endcase
		// queued byte goes out, else the write ends
		if (nextTx) begin
			if (s.txValid) begin
				n.by = BY_TX;
				n.shift = s.txHold;
				n.txValid = 1'b0;
				contin = 1'b1;
			end else begin
				stopNow = 1'b1;
			end
		end
		if (contin) begin
			n.st = ST_LOW;
			n.sclLow = 1'b1;
			n.tmrGo = 1'b1;
			n.sdaLow = lowDrive(n.by, n.bitIdx, n.shift, n.rxLeft);
		end
		if (stopNow) begin
			n.st = ST_STOP_LOW;
			n.sclLow = 1'b1;
			n.sdaLow = 1'b1;
			n.tmrGo = 1'b1;
		end
		// slave transmitter, driven from synchronised pin edges
		n.sclPrev = sclS;
		n.sdaPrev = sdaS;
		sRise = sclS && !s.sclPrev;
		sFall = !sclS && s.sclPrev;
		sStart = sclS && s.sclPrev && s.sdaPrev && !sdaS;
		sStop = sclS && s.sclPrev && !s.sdaPrev && sdaS;
		if (sStart && s.scon[SCON_SEN]) begin
			n.sl = SL_ADDR;
			n.sCnt = 4'h0;
			n.sSdaLow = 1'b0;
		end else if (sStop || sStart) begin
			n.sl = SL_IDLE;
			n.sSdaLow = 1'b0;
		end else begin
			case (s.sl)
				SL_ADDR: if (sRise) begin
					if (s.sCnt == ACK_BIT) begin
						n.sl = s.sSdaLow ? SL_TX : SL_SKIP;
						n.sCnt = 4'h0;
					end else begin
						n.sShift = {s.sShift[6:0], sdaS};
						n.sCnt = s.sCnt + 4'h1;
					end
				end else if (sFall && s.sCnt == ACK_BIT && s.sShift == {s.sOwn, 1'b1}) begin
					// only a read of our own address is answered
					n.sSdaLow = 1'b1;
					n.sShift = s.sTx;
				end
				SL_TX: if (sFall) begin
					n.sSdaLow = (s.sCnt != ACK_BIT) && !s.sShift[7];
				end else if (sRise) begin
					if (s.sCnt != ACK_BIT) begin
						n.sShift = {s.sShift[6:0], 1'b0};
						n.sCnt = s.sCnt + 4'h1;
						stxEvt = (s.sCnt == 4'h7);
					end else if (sdaS) begin
						n.sl = SL_SKIP;
					end else begin
						n.sCnt = 4'h0;
						n.sShift = s.sTx;
					end
				end
				default: n.sSdaLow = 1'b0;
			endcase
		end
		// register writes land after the engine so a fresh byte is not lost
		if (wrAcc) begin
			if (sel[R_MTX]) begin
				n.txHold = pwdata[7:0];
				n.txValid = 1'b1;
			end else if (sel[R_MCNT]) n.rdCnt = pwdata[8:0];
			else if (sel[R_ADR0]) n.adr0 = pwdata[7:0];
			else if (sel[R_ADR1]) n.adr1 = pwdata[7:0];
			else if (sel[R_DIV]) n.div = pwdata[15:0];
			else if (sel[R_SCON]) n.scon = pwdata[10:0];
			else if (sel[R_MCTL]) n.tenBit = pwdata[CTL_TEN];
			else if (sel[R_IMSK]) n.irqMsk = pwdata[3:0];
			else if (sel[R_SOWN]) n.sOwn = pwdata[6:0];
			else if (sel[R_STX]) n.sTx = pwdata[7:0];
		end
		// read data captured in the setup cycle
		if (psel && !penable) n.rdata = rdMux;
		// status clears on read, a same-cycle event wins
		if (rdAcc && sel[R_IST]) n.irqSt = 4'h0;
		if (doneEvt) n.irqSt[IRQ_DONE] = 1'b1;
		if (rxEvt) n.irqSt[IRQ_MRX] = 1'b1;
		if (nackEvt) n.irqSt[IRQ_NACK] = 1'b1;
		if (stxEvt && s.scon[SCON_STXENI]) n.irqSt[IRQ_STX] = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= '0;
			s.st <= ST_IDLE;
			s.by <= BY_ADDR;
			s.sl <= SL_IDLE;
			s.rdCnt <= MCNT_RST;
			s.div <= DIV_RST;
			s.sclPrev <= 1'b1;
			s.sdaPrev <= 1'b1;
		end else begin
			s <= n;
		end
	end

	// pins are open drain: only ever pulled low
	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOe = s.sclLow;
	assign sdaOe = s.sdaLow || s.sSdaLow;
	assign irq = |(s.irqSt & s.irqMsk);

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence sGoSeven;
		s.st == ST_IDLE && goReq && !pwdata[CTL_TEN];
	endsequence
	sequence sGoTen;
		s.st == ST_IDLE && goReq && pwdata[CTL_TEN];
	endsequence
	property p_addrSeven;
		sGoSeven |=> s.shift == $past(s.adr0) ##1 s.tmrGo == 1'b0 && s.st == ST_START;
	endproperty
	a_addrSeven: assert property (p_addrSeven) else $error("7-bit header not from address register");
	property p_direction;
		(s.by == BY_RX || s.by == BY_TX) |-> s.isRead == (s.by == BY_RX);
	endproperty
	a_direction: assert property (p_direction) else $error("transfer direction disagrees with rw bit");
	property p_tenUpper;
		sGoTen |=> s.shift[2:1] == $past(s.adr0[2:1]) && !s.shift[0];
	endproperty
	a_tenUpper: assert property (p_tenUpper) else $error("10-bit upper pair wrong");
	property p_tenLower;
		$rose(s.by == BY_ADDR2) |-> s.tenBit && s.shift == s.adr1;
	endproperty
	a_tenLower: assert property (p_tenLower) else $error("10-bit low byte wrong");
	property p_highTime;
		s.tmrGo && s.st == ST_HIGH |-> tmrLen == s.div[15:8] ##1 !sclOe [*2];
	endproperty
	a_highTime: assert property (p_highTime) else $error("scl high phase mistimed");
	property p_lowTime;
		s.tmrGo && s.st == ST_LOW |-> tmrLen == s.div[7:0] ##1 sclOe [*2];
	endproperty
	a_lowTime: assert property (p_lowTime) else $error("scl low phase mistimed");
	property p_rxCount;
		rxEvt |=> s.prog == $past(s.prog) + 8'h01 && s.irqSt[IRQ_MRX];
	endproperty
	a_rxCount: assert property (p_rxCount) else $error("receive count not advanced");
	property p_slaveTxIrq;
		stxEvt && s.scon[SCON_STXENI] && s.irqMsk[IRQ_STX] |=> irq;
	endproperty
	a_slaveTxIrq: assert property (p_slaveTxIrq) else $error("slave transmit interrupt missing");
	property p_txQueue;
		wrAcc && sel[R_MTX] |=> s.txValid && s.txHold == $past(pwdata[7:0]);
	endproperty
	a_txQueue: assert property (p_txQueue) else $error("transmit byte not queued");
endmodule : i2ac_top

// ==== test/i2ac_bus_slave.sv ====
// behavioural two-wire bus slave facing the master engine
`timescale 1ns/1ps
module i2ac_bus_slave #(
	parameter logic [6:0] ADDR7 = 7'h2A,
	parameter logic [9:0] ADDR10 = 10'h23C,
	parameter logic [7:0] DATA_BASE = 8'hC0
) (
	input wire logic sclW,
	input wire logic sdaW,
	output logic sdaOe,
	output logic [7:0] hdrByte,
	output logic [7:0] lastRx,
	output int rxCount,
	output int txCount
);
	logic [7:0] sh;
	logic [7:0] txB;
	int bitIdx = 0;
	int nByte = 0;
	logic rd = 0, live = 0, send = 0, ten = 0, acked = 0, mNack = 0;
	initial sdaOe = 0;
	// ---------------------------------------------------------------
	// framing
	// ---------------------------------------------------------------
	// start or repeated start restarts the byte count; the short pause keeps a data
	// change in the same step as a clock fall from being taken for a start
	always @(negedge sdaW) begin
		#1;
		if (sclW) begin
			bitIdx = 0;
			nByte = 0;
			live = 1;
			send = 0;
			sdaOe = 0;
			rxCount = 0;
			txCount = 0;
		end
	end
	// stop ends the frame, with the same pause against a false stop
	always @(posedge sdaW) begin
		#1;
		if (sclW) live = 0;
	end
	// bits are sampled while the clock is high
	always @(posedge sclW) if (live) begin
		if (bitIdx < 8) sh = {sh[6:0], sdaW};
		else mNack = sdaW;
		bitIdx++;
	end
	// the pin moves after a falling clock, and while high only to release at a start
	always @(negedge sclW) if (live) begin
		if (bitIdx == 9) begin
			bitIdx = 0;
			nByte++;
			sdaOe = 0;
			send = rd && acked && (!send || !mNack);
			if (send) begin
				txB = DATA_BASE + 8'(txCount);
				sdaOe = ~txB[7];
			end
		end else if (send && bitIdx < 8) begin
			sdaOe = ~txB[7 - bitIdx];
		end else if (send) begin
			sdaOe = 0; // released for the master's ack
			txCount++;
		end else if (bitIdx == 8) begin
			if (nByte == 0) begin
				hdrByte = sh;
				rd = sh[0];
				ten = (sh[7:3] == 5'h1E);
				acked = ten ? (sh[2:1] == ADDR10[9:8]) : (sh[7:1] == ADDR7);
			end else if (ten && nByte == 1 && !rd) begin
				acked = (sh == ADDR10[7:0]);
			end else begin
				lastRx = sh;
				rxCount++;
			end
			sdaOe = acked;
		end
	end
endmodule : i2ac_bus_slave

// ==== test/i2ac_top_test.sv ====
// self-checking bench for the two-wire controller over apb
`timescale 1ns/1ps
module i2ac_top_test
	import i2ac_pkg::*;
;
	logic sys_clk, reset_n, psel, penable, pwrite;
	logic [31:0] paddr, pwdata, prdata, q;
	logic pready, pslverr, irq, sclOut, sclOe, sdaOut, sdaOe, slvOe, e;
	wire logic sclW, sdaW;
	logic [7:0] hdrByte, lastRx;
	int rxCount, txCount, err_count, comparisons, cyc, run, lowLen, highLen;
	logic sclPrev;
	logic [31:0] rstA[7] = '{ADDR_MTX, ADDR_MCNT, ADDR_PROG, ADDR_ADR0, ADDR_ADR1, ADDR_DIV, ADDR_SCON};
	logic [31:0] rstV[7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1F1F, 32'h0};
	logic [31:0] cntTab[3] = '{32'h0, 32'h2, 32'h100};
	// pull-ups on both lines: low while any party pulls
	assign sclW = !sclOe;
	assign sdaW = !(sdaOe | slvOe);
	i2ac_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe));
	i2ac_bus_slave slv_u (.sclW(sclW), .sdaW(sdaW), .sdaOe(slvOe), .hdrByte(hdrByte), .lastRx(lastRx),
		.rxCount(rxCount), .txCount(txCount));
	initial begin
		sys_clk = 0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// ---------------------------------------------------------------
	// clock phase lengths and run limit
	// ---------------------------------------------------------------
	// lengths in cycles of the last low and high phase of the line
	always @(posedge sys_clk) begin
		run <= run + 1;
		sclPrev <= sclW;
		if (sclW !== sclPrev) begin
			run <= 1;
			if (sclPrev === 1'b1) highLen <= run;
			else lowLen <= run;
		end
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_count++;
			summarize();
		end
	end
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic summarize;
		if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// irq is looked at mid-cycle, clear of the edge that moves it
	task automatic irqChk(input logic exp);
		@(negedge sys_clk);
		chk({31'h0, irq}, {31'h0, exp});
	endtask : irqChk
	// one apb transfer; waits for pready with no assumed latency
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic er);
		@(posedge sys_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		// only the bench's cycle ceiling bounds this wait
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		r = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic wr32(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic er;
		apb(1'b1, a, d, r, er);
	endtask : wr32
	task automatic rdChk(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic er;
		apb(1'b0, a, 32'h0, r, er);
		chk(r, exp);
	endtask : rdChk
	// start the engine and poll busy under a bound
	task automatic runMaster(input logic [31:0] ctl);
		logic [31:0] r;
		logic er;
		int n = 0;
		wr32(ADDR_MCTL, ctl);
		do begin
			apb(1'b0, ADDR_MCTL, 32'h0, r, er);
			n++;
		end while (r[CTL_GO] !== 1'b0 && n < 20000);
		chk({31'h0, r[CTL_GO]}, 32'h0);
	endtask : runMaster
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		reset_n = 0;
		repeat (5) @(posedge sys_clk);
		reset_n <= 1;
		// reset values, read-only progress, unmapped place
		for (int i = 0; i < 7; i++) rdChk(rstA[i], rstV[i]);
		wr32(ADDR_PROG, 32'h5A);
		rdChk(ADDR_PROG, 32'h0);
		wr32(ADDR_SCON, 32'h400);
		rdChk(ADDR_SCON, 32'h400);
		apb(1'b0, 32'hFFFF0920, 32'h0, q, e);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		// 7-bit write with short phases
		wr32(ADDR_DIV, 32'h0503);
		wr32(ADDR_ADR0, 32'h54);
		wr32(ADDR_MTX, 32'hA5);
		runMaster(32'h1);
		chk({24'h0, hdrByte}, 32'h54);
		chk({24'h0, lastRx}, 32'hA5);
		chk(32'(rxCount), 32'h1);
		chk(32'(lowLen), 32'h5);
		chk(32'(highLen), 32'h7);
		// done event: masked, then unmasked, then cleared by reading
		irqChk(1'b0);
		wr32(ADDR_IMSK, 32'h1);
		irqChk(1'b1);
		rdChk(ADDR_IST, 32'h1);
		irqChk(1'b0);
		rdChk(ADDR_IST, 32'h0);
		// reads of one, three and 257 bytes; the last wraps progress
		for (int i = 0; i < 3; i++) begin
			wr32(ADDR_MCNT, cntTab[i]);
			wr32(ADDR_ADR0, 32'h55);
			runMaster(32'h1);
			chk({24'h0, hdrByte}, 32'h55);
			chk(32'(txCount), cntTab[i] + 1);
			rdChk(ADDR_PROG, (cntTab[i] + 1) & 32'hFF);
			rdChk(ADDR_MRX, (32'hC0 + cntTab[i]) & 32'hFF);
			rdChk(ADDR_IST, 32'h3);
		end
		// nobody answers this address
		wr32(ADDR_ADR0, 32'h60);
		runMaster(32'h1);
		apb(1'b0, ADDR_IST, 32'h0, q, e);
		chk({31'h0, q[IRQ_NACK]}, 32'h1);
		// 10-bit write: prefix and top pair in first register, low byte in second
		wr32(ADDR_ADR0, 32'hF4);
		wr32(ADDR_ADR1, 32'h3C);
		wr32(ADDR_MTX, 32'h96);
		runMaster(32'h3);
		chk({24'h0, hdrByte}, 32'hF4);
		chk({24'h0, lastRx}, 32'h96);
		chk(32'(rxCount), 32'h1);
		// 10-bit read: write header, low byte, repeated start, header with read bit
		wr32(ADDR_MCNT, 32'h0);
		wr32(ADDR_ADR0, 32'hF5);
		runMaster(32'h3);
		chk({24'h0, hdrByte}, 32'hF5);
		rdChk(ADDR_MRX, 32'hC0);
		// own slave answers our own read; its sent byte raises the slave interrupt
		wr32(ADDR_SOWN, 32'h2B);
		wr32(ADDR_STX, 32'h3C);
		wr32(ADDR_SCON, 32'h401);
		wr32(ADDR_IMSK, 32'h8);
		irqChk(1'b0);
		wr32(ADDR_ADR0, 32'h57);
		runMaster(32'h1);
		rdChk(ADDR_MRX, 32'h3C);
		irqChk(1'b1);
		rdChk(ADDR_IST, 32'hB);
		summarize();
	end
endmodule : i2ac_top_test
